// *** rtl/psa_access_top.sv ***
// Functional notes
// (R01) Program space is 4M words, reached by a 24-bit address.
// (R02) Successive program words sit two addresses apart.
// (R03) User accesses stay below 0x800000; table page bit 7 picks config space.
// (R04) Address bit 23 is zero except for table access to config space.
// (R05) Table address is table page above the 16-bit effective address.
// (R06) Word low table read returns program bits 15:0.
// (R07) Byte low table read returns byte 0 or byte 1 by byte select.
// (R08) Word high table read returns bits 23:16 with upper byte zero.
// (R09) Byte high table read returns bits 23:16, or zero on select one.
// (R10) Upper program byte reachable only by high table read and write.
// (R11) Window access needs address bit 15 and the visibility enable.
// (R12) Upper 32 Kbytes of data map onto the selected 16K-word page.
// (R13) Window address: visibility page above the low 15 address bits.
// (R14) Window reads return only the low 16 bits of the word.
// (R15) Upper half of data space is always X space.
// (R16) Table operations never use the window mapping.
// (R17) Short ops through the window outside a loop take one extra cycle.
// (R18) Other window accesses outside a loop take two extra cycles.
// (R19) Loop edge and interrupt iterations take two extra cycles.
// (R20) Other loop iterations take no extra cycles.
// (R21) Without the enable, upper addresses go to data memory, no delay.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Program space address construction and data access
module psa_access_top (
  input wire logic clock, // Core instruction clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic table_page_we, // Load table_page_reg
  input wire logic [7:0] table_page_wdata, // New table page
  input wire logic visibility_page_we, // Load visibility_page_reg
  input wire logic [7:0] visibility_page_wdata, // New visibility page
  input wire logic program_visibility_enable, // Window enable from core_control_reg
  input wire logic req_valid, // Access request
  input wire logic [2:0] req_kind, // Access kind
  input wire logic req_byte, // Byte sized access
  input wire logic [15:0] req_ea, // Effective address
  input wire logic [22:0] req_pc, // Program counter
  input wire logic [15:0] req_wdata, // Write data
  input wire logic req_short_op, // Move, double move or prefetch op
  input wire logic req_in_repeat, // Executed inside a repeat loop
  input wire logic req_rep_edge, // First, last or interrupt iteration
  output logic req_ready, // Ready for a request
  output logic rsp_valid, // Access complete
  output logic [15:0] rsp_data, // Read data
  output logic [23:0] pm_addr, // Program memory address
  output logic pm_rd, // Program memory read strobe
  output logic [1:0] pm_wr_lo, // Low word byte write enables
  output logic pm_wr_hi, // High byte write enable
  output logic [23:0] pm_wdata, // Program memory write data
  input wire logic [23:0] pm_rdata, // Program memory read data
  output logic [15:0] dm_addr, // Data memory address
  output logic dm_rd, // Data memory read strobe
  output logic dm_wr, // Data memory write strobe
  output logic dm_byte, // Data memory byte access
  output logic [15:0] dm_wdata, // Data memory write data
  input wire logic [15:0] dm_rdata, // Data memory read data
  output logic x_space, // Access lies in X space upper half
  output logic psv_active, // Access served through the window
  output logic [23:0] next_pc_addr, // Address of the following word
  output logic [7:0] table_page, // table_page_reg value
  output logic [7:0] visibility_page // visibility_page_reg value
);

  // ==========================================================
  // State
  psa_pkg::psa_state_t state_r, state_nxt;
  psa_pkg::psa_kind_t kind_r, kind_nxt;
  logic [7:0] tpage_r, tpage_nxt;
  logic [7:0] vpage_r, vpage_nxt;
  logic byte_r, byte_nxt;
  logic sel_r, sel_nxt;
  logic [1:0] extra_r, extra_nxt;
  logic ready_r, ready_nxt;
  logic rsp_valid_r, rsp_valid_nxt;
  logic [15:0] rsp_data_r, rsp_data_nxt;
  logic [23:0] pm_addr_r, pm_addr_nxt;
  logic pm_rd_r, pm_rd_nxt;
  logic [1:0] pm_wr_lo_r, pm_wr_lo_nxt;
  logic pm_wr_hi_r, pm_wr_hi_nxt;
  logic [23:0] pm_wdata_r, pm_wdata_nxt;
  logic [15:0] dm_addr_r, dm_addr_nxt;
  logic dm_rd_r, dm_rd_nxt;
  logic dm_wr_r, dm_wr_nxt;
  logic dm_byte_r, dm_byte_nxt;
  logic [15:0] dm_wdata_r, dm_wdata_nxt;
  logic x_space_r, x_space_nxt;
  logic psv_r, psv_nxt;
  logic [23:0] next_pc_r, next_pc_nxt;

  logic take;
  logic is_data;
  logic hit_psv;
  logic stretch_zero;
  logic [15:0] ext_data;
  psa_pkg::psa_kind_t req_k;

  assign req_k = psa_pkg::psa_kind_t'(req_kind);
  assign take = (state_r == psa_pkg::PSA_S_IDLE) && req_valid;
  assign is_data = (req_k == psa_pkg::PSA_K_DATA_RD) || (req_k == psa_pkg::PSA_K_DATA_WR);
  // Window decode skips table kinds entirely
  assign hit_psv = is_data && req_ea[psa_pkg::PSA_EA_MSB] && program_visibility_enable; // R11 R16

  // ==========================================================
  // Submodules
  psa_extract u_extract (
    .kind(kind_r),
    .byte_op(byte_r),
    .byte_sel(sel_r),
    .from_pgm(psv_r),
    .pword(pm_rdata),
    .dword(dm_rdata),
    .data(ext_data)
  );

  psa_stretch #(.W(2)) u_stretch (
    .clock(clock),
    .reset(reset),
    .load(state_r == psa_pkg::PSA_S_CAPT),
    .count(extra_r),
    .zero(stretch_zero)
  );

  // ==========================================================
  // Next state and outputs
  always_comb
  begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    tpage_nxt = table_page_we ? table_page_wdata : tpage_r;
    vpage_nxt = visibility_page_we ? visibility_page_wdata : vpage_r;
    byte_nxt = byte_r;
    sel_nxt = sel_r;
    extra_nxt = extra_r;
    ready_nxt = ready_r;
    rsp_valid_nxt = 1'b0;
    rsp_data_nxt = rsp_data_r;
    pm_addr_nxt = pm_addr_r;
    pm_rd_nxt = 1'b0;
    pm_wr_lo_nxt = psa_pkg::PSA_BE_NONE;
    pm_wr_hi_nxt = 1'b0;
    pm_wdata_nxt = pm_wdata_r;
    dm_addr_nxt = dm_addr_r;
    dm_rd_nxt = 1'b0;
    dm_wr_nxt = 1'b0;
    dm_byte_nxt = dm_byte_r;
    dm_wdata_nxt = dm_wdata_r;
    x_space_nxt = x_space_r;
    psv_nxt = psv_r;
    next_pc_nxt = next_pc_r;
    case (state_r)
      psa_pkg::PSA_S_IDLE:
      begin
        if (take)
        begin
          state_nxt = psa_pkg::PSA_S_ISSUE;
          ready_nxt = 1'b0;
          kind_nxt = req_k;
          byte_nxt = req_byte;
          sel_nxt = req_ea[0];
          psv_nxt = hit_psv;
          x_space_nxt = is_data && req_ea[psa_pkg::PSA_EA_MSB]; // R15
          extra_nxt = hit_psv ? psa_pkg::psa_psv_extra(req_in_repeat, req_rep_edge,
                                                       req_short_op)
                              : psa_pkg::PSA_EXTRA_NONE; // R17 R18 R19 R20 R21
          case (req_k)
            psa_pkg::PSA_K_FETCH:
            begin
              // User fetch keeps bit 23 and bit 0 clear
              pm_addr_nxt = {psa_pkg::PSA_TOP_USER, req_pc[22:1], psa_pkg::PSA_LSB_ZERO}; // R01 R03 R04
              next_pc_nxt = {psa_pkg::PSA_TOP_USER, req_pc[22:1], psa_pkg::PSA_LSB_ZERO}
                            + psa_pkg::PSA_PC_STEP; // R02
              pm_rd_nxt = 1'b1;
            end
            psa_pkg::PSA_K_TRD_LO, psa_pkg::PSA_K_TRD_HI:
            begin
              // Page bit 7 lands on address bit 23 and picks config space
              pm_addr_nxt = {tpage_r, req_ea}; // R05 R03 R04
              pm_rd_nxt = 1'b1;
            end
            psa_pkg::PSA_K_TWR_LO:
            begin
              pm_addr_nxt = {tpage_r, req_ea}; // R05
              pm_wdata_nxt = {psa_pkg::PSA_ZERO_BYTE, req_wdata};
              pm_wr_lo_nxt = psa_pkg::PSA_BE_BOTH;
              if (req_byte)
              begin
                pm_wdata_nxt = {psa_pkg::PSA_ZERO_BYTE, req_wdata[7:0], req_wdata[7:0]};
                pm_wr_lo_nxt = req_ea[0] ? psa_pkg::PSA_BE_HIGH : psa_pkg::PSA_BE_LOW;
              end
            end
            psa_pkg::PSA_K_TWR_HI:
            begin
              // Only path that writes the upper program byte
              pm_addr_nxt = {tpage_r, req_ea}; // R05 R10
              pm_wdata_nxt = {req_wdata[7:0], psa_pkg::PSA_ZERO_BYTE, psa_pkg::PSA_ZERO_BYTE};
              pm_wr_hi_nxt = !(req_byte && req_ea[0]);
            end
            default:
            begin
              if (hit_psv)
              begin
                // Window: page above the low 15 address bits
                pm_addr_nxt = {psa_pkg::PSA_TOP_USER, vpage_r,
                               req_ea[psa_pkg::PSA_WIN_W-1:0]}; // R12 R13 R04
                pm_rd_nxt = (req_k == psa_pkg::PSA_K_DATA_RD); // R10 R14
              end
              else
              begin
                dm_addr_nxt = req_ea; // R21
                dm_byte_nxt = req_byte;
                dm_wdata_nxt = req_wdata;
                dm_rd_nxt = (req_k == psa_pkg::PSA_K_DATA_RD);
                dm_wr_nxt = (req_k == psa_pkg::PSA_K_DATA_WR);
              end
            end
          endcase
        end
      end
      psa_pkg::PSA_S_ISSUE:
      begin
        state_nxt = psa_pkg::PSA_S_CAPT;
      end
      psa_pkg::PSA_S_CAPT:
      begin
        rsp_data_nxt = ext_data; // R06 R07 R08 R09 R14
        state_nxt = psa_pkg::PSA_S_STRETCH;
      end
      psa_pkg::PSA_S_STRETCH:
      begin
        if (stretch_zero)
        begin
          state_nxt = psa_pkg::PSA_S_RESP;
          rsp_valid_nxt = 1'b1;
        end
      end
      psa_pkg::PSA_S_RESP:
      begin
        state_nxt = psa_pkg::PSA_S_IDLE;
        ready_nxt = 1'b1;
      end
      default:
      begin
        state_nxt = psa_pkg::PSA_S_IDLE;
        ready_nxt = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_r <= psa_pkg::PSA_S_IDLE;
      kind_r <= psa_pkg::PSA_K_FETCH;
      tpage_r <= psa_pkg::PSA_PAGE_RST;
      vpage_r <= psa_pkg::PSA_PAGE_RST;
      byte_r <= 1'b0;
      sel_r <= 1'b0;
      extra_r <= psa_pkg::PSA_EXTRA_NONE;
      ready_r <= 1'b1;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= '0;
      pm_addr_r <= '0;
      pm_rd_r <= 1'b0;
      pm_wr_lo_r <= psa_pkg::PSA_BE_NONE;
      pm_wr_hi_r <= 1'b0;
      pm_wdata_r <= '0;
      dm_addr_r <= '0;
      dm_rd_r <= 1'b0;
      dm_wr_r <= 1'b0;
      dm_byte_r <= 1'b0;
      dm_wdata_r <= '0;
      x_space_r <= 1'b0;
      psv_r <= 1'b0;
      next_pc_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      tpage_r <= tpage_nxt;
      vpage_r <= vpage_nxt;
      byte_r <= byte_nxt;
      sel_r <= sel_nxt;
      extra_r <= extra_nxt;
      ready_r <= ready_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_data_r <= rsp_data_nxt;
      pm_addr_r <= pm_addr_nxt;
      pm_rd_r <= pm_rd_nxt;
      pm_wr_lo_r <= pm_wr_lo_nxt;
      pm_wr_hi_r <= pm_wr_hi_nxt;
      pm_wdata_r <= pm_wdata_nxt;
      dm_addr_r <= dm_addr_nxt;
      dm_rd_r <= dm_rd_nxt;
      dm_wr_r <= dm_wr_nxt;
      dm_byte_r <= dm_byte_nxt;
      dm_wdata_r <= dm_wdata_nxt;
      x_space_r <= x_space_nxt;
      psv_r <= psv_nxt;
      next_pc_r <= next_pc_nxt;
    end
  end

  // Output wiring
  assign req_ready = ready_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;
  assign pm_addr = pm_addr_r;
  assign pm_rd = pm_rd_r;
  assign pm_wr_lo = pm_wr_lo_r;
  assign pm_wr_hi = pm_wr_hi_r;
  assign pm_wdata = pm_wdata_r;
  assign dm_addr = dm_addr_r;
  assign dm_rd = dm_rd_r;
  assign dm_wr = dm_wr_r;
  assign dm_byte = dm_byte_r;
  assign dm_wdata = dm_wdata_r;
  assign x_space = x_space_r;
  assign psv_active = psv_r;
  assign next_pc_addr = next_pc_r;
  assign table_page = tpage_r;
  assign visibility_page = vpage_r;

  // ==========================================================
  // Checks
  AST_FETCH_ADDR: assert property (@(posedge clock) disable iff (reset) // R01
    take && req_k == psa_pkg::PSA_K_FETCH |=> pm_rd && pm_addr[22:1] == $past(req_pc[22:1]))
    else $error("fetch address not built from program counter");

  AST_PC_STEP: assert property (@(posedge clock) disable iff (reset) // R02
    pm_rd && kind_r == psa_pkg::PSA_K_FETCH |-> next_pc_addr == pm_addr + psa_pkg::PSA_PC_STEP)
    else $error("next word address not two ahead");

  AST_BIT23_CLEAR: assert property (@(posedge clock) disable iff (reset) // R04
    (pm_rd || pm_wr_hi) && !psa_pkg::psa_is_table(kind_r) |-> !pm_addr[23] && !pm_wr_hi)
    else $error("bit 23 set outside table access");

  AST_TABLE_ADDR: assert property (@(posedge clock) disable iff (reset) // R05
    take && psa_pkg::psa_is_table(req_k) |=> pm_addr == {$past(tpage_r), $past(req_ea)})
    else $error("table address not page over effective address");

  AST_TRD_LO_WORD: assert property (@(posedge clock) disable iff (reset) // R06
    state_r == psa_pkg::PSA_S_CAPT && kind_r == psa_pkg::PSA_K_TRD_LO && !byte_r
    |=> rsp_data == $past(pm_rdata[15:0]))
    else $error("low table word read mismatch");

  AST_TRD_HI_ZERO: assert property (@(posedge clock) disable iff (reset) // R08
    state_r == psa_pkg::PSA_S_CAPT && kind_r == psa_pkg::PSA_K_TRD_HI
    |=> rsp_data[15:8] == 8'h00 && (byte_r && sel_r || rsp_data[7:0] == $past(pm_rdata[23:16])))
    else $error("high table read not zero extended");

  AST_PSV_ROUTE: assert property (@(posedge clock) disable iff (reset) // R11
    take && req_k == psa_pkg::PSA_K_DATA_RD && hit_psv
    |=> pm_rd && !dm_rd && pm_addr == {1'b0, $past(vpage_r), $past(req_ea[14:0])})
    else $error("window read not routed to program memory");

  AST_NO_PSV: assert property (@(posedge clock) disable iff (reset) // R21
    take && req_k == psa_pkg::PSA_K_DATA_RD && !program_visibility_enable
    |=> dm_rd && !pm_rd ##3 rsp_valid)
    else $error("disabled window access misrouted or delayed");

  AST_X_SPACE: assert property (@(posedge clock) disable iff (reset) // R15
    take && is_data && req_ea[15] |=> x_space)
    else $error("upper data half not flagged as X space");

  AST_SHORT_STRETCH: assert property (@(posedge clock) disable iff (reset) // R17
    take && hit_psv && !req_in_repeat && req_short_op |-> !rsp_valid [*5] ##1 rsp_valid)
    else $error("short window op not stretched by one");

  AST_LONG_STRETCH: assert property (@(posedge clock) disable iff (reset) // R18
    take && hit_psv && !req_in_repeat && !req_short_op |-> ##5 !rsp_valid ##1 rsp_valid)
    else $error("window op not stretched by two");

  AST_LOOP_EDGE: assert property (@(posedge clock) disable iff (reset) // R19
    take && hit_psv && req_in_repeat && req_rep_edge |-> ##6 rsp_valid)
    else $error("loop edge iteration not stretched by two");

  AST_LOOP_BODY: assert property (@(posedge clock) disable iff (reset) // R20
    take && hit_psv && req_in_repeat && !req_rep_edge |-> ##4 rsp_valid)
    else $error("loop body iteration stretched");

endmodule : psa_access_top
`default_nettype wire

// *** rtl/psa_pkg.sv ***
`default_nettype none
// ==========================================================
// Program space access constants
package psa_pkg;

  // Widths of addresses and data
  localparam int PSA_PA_W = 24;
  localparam int PSA_EA_W = 16;
  localparam int PSA_PAGE_W = 8;
  localparam int PSA_PC_W = 23;
  localparam int PSA_PWORD_W = 24;
  localparam int PSA_DWORD_W = 16;
  localparam int PSA_BYTE_W = 8;
  localparam int PSA_WIN_W = 15;

  // Field positions
  localparam int PSA_EA_MSB = 15;
  localparam int PSA_PAGE_CFG_BIT = 7;

  // Address step between program words
  localparam logic [23:0] PSA_PC_STEP = 24'h000002;

  // Fixed address bits
  localparam logic PSA_TOP_USER = 1'b0;
  localparam logic PSA_LSB_ZERO = 1'b0;
  localparam logic [7:0] PSA_ZERO_BYTE = 8'h00;

  // Byte enables of the low program word
  localparam logic [1:0] PSA_BE_BOTH = 2'h3;
  localparam logic [1:0] PSA_BE_LOW = 2'h1;
  localparam logic [1:0] PSA_BE_HIGH = 2'h2;
  localparam logic [1:0] PSA_BE_NONE = 2'h0;

  // Reset values of the page registers
  localparam logic [7:0] PSA_PAGE_RST = 8'h00;

  // Extra cycles of a window access
  localparam logic [1:0] PSA_EXTRA_NONE = 2'h0;
  localparam logic [1:0] PSA_EXTRA_SHORT = 2'h1;
  localparam logic [1:0] PSA_EXTRA_LONG = 2'h2;

  // Access kinds issued by the core
  typedef enum logic [2:0] {
    PSA_K_FETCH = 3'h0,
    PSA_K_TRD_LO = 3'h1,
    PSA_K_TRD_HI = 3'h2,
    PSA_K_TWR_LO = 3'h3,
    PSA_K_TWR_HI = 3'h4,
    PSA_K_DATA_RD = 3'h5,
    PSA_K_DATA_WR = 3'h6
  } psa_kind_t;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    PSA_S_IDLE = 5'h01,
    PSA_S_ISSUE = 5'h02,
    PSA_S_CAPT = 5'h04,
    PSA_S_STRETCH = 5'h08,
    PSA_S_RESP = 5'h10
  } psa_state_t;

  // Extra cycles of a window access from its loop context
  function automatic logic [1:0] psa_psv_extra(input logic in_rep, input logic edge_iter,
                                               input logic short_op);
    if (in_rep)
    begin
      return edge_iter ? PSA_EXTRA_LONG : PSA_EXTRA_NONE;
    end
    return short_op ? PSA_EXTRA_SHORT : PSA_EXTRA_LONG;
  endfunction : psa_psv_extra

  // True for access kinds that are table operations
  function automatic logic psa_is_table(input psa_kind_t k);
    return (k == PSA_K_TRD_LO) || (k == PSA_K_TRD_HI) ||
           (k == PSA_K_TWR_LO) || (k == PSA_K_TWR_HI);
  endfunction : psa_is_table

endpackage : psa_pkg
`default_nettype wire

// *** rtl/psa_extract.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Read data extraction for table and window reads
module psa_extract (
  input wire logic [2:0] kind, // Access kind
  input wire logic byte_op, // Byte sized access
  input wire logic byte_sel, // Byte select, low address bit
  input wire logic from_pgm, // Data read served by program memory
  input wire logic [23:0] pword, // Program word read
  input wire logic [15:0] dword, // Data word read
  output logic [15:0] data // Extracted data
);

  logic [15:0] src;

  // Lane selection per kind
  always_comb
  begin
    src = from_pgm ? pword[15:0] : dword;
    data = src;
    case (kind)
      psa_pkg::PSA_K_TRD_LO:
      begin
        data = pword[15:0]; // R06
        if (byte_op)
        begin
          data = {psa_pkg::PSA_ZERO_BYTE, byte_sel ? pword[15:8] : pword[7:0]}; // R07
        end
      end
      psa_pkg::PSA_K_TRD_HI:
      begin
        data = {psa_pkg::PSA_ZERO_BYTE, pword[23:16]}; // R08 R10
        if (byte_op && byte_sel)
        begin
          data = {psa_pkg::PSA_ZERO_BYTE, psa_pkg::PSA_ZERO_BYTE}; // R09
        end
      end
      psa_pkg::PSA_K_DATA_RD:
      begin
        if (byte_op)
        begin
          data = {psa_pkg::PSA_ZERO_BYTE, byte_sel ? src[15:8] : src[7:0]};
        end
      end
      default:
      begin
        data = src;
      end
    endcase
  end

endmodule : psa_extract
`default_nettype wire

// *** rtl/psa_stretch.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Down counter that holds the sequencer for extra cycles
module psa_stretch #(
  parameter int W = 2 // Counter width
) (
  input wire logic clock, // Core clock
  input wire logic reset, // Synchronous reset
  input wire logic load, // Load a new count
  input wire logic [W-1:0] count, // Extra cycles to wait
  output logic zero // Count exhausted
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // Next count
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (load)
    begin
      cnt_nxt = count;
    end
    else if (cnt_r != '0)
    begin
      cnt_nxt = cnt_r - W'(1);
    end
  end

  // Count register
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  assign zero = (cnt_r == '0);

endmodule : psa_stretch
`default_nettype wire

// *** dv/psa_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Program and data memory facing the access block
module psa_mem_model (
  input wire logic clock, // Core clock
  input wire logic [23:0] pm_addr, // Program address
  input wire logic pm_rd, // Program read strobe
  output logic [23:0] pm_rdata, // Program word
  input wire logic [15:0] dm_addr, // Data address
  input wire logic dm_rd, // Data read strobe
  output logic [15:0] dm_rdata // Data word
);
  // Word contents follow from the word address, byte select ignored
  function automatic logic [23:0] pword(input logic [23:0] a);
    return ({a[23:1], 1'b0} * 24'h00B3C5) ^ 24'h5A3C96;
  endfunction : pword

  function automatic logic [15:0] dword(input logic [15:0] a);
    return {a[7:1], 1'b0, a[15:8]} ^ 16'hC3A5;
  endfunction : dword

  // One-cycle read latency; lines invert every cycle afterwards so data one cycle stale does not match
  initial
  begin
    pm_rdata = 24'h000000;
    dm_rdata = 16'h0000;
  end

  always @(posedge clock)
  begin
    pm_rdata <= pm_rd ? pword(pm_addr) : ~pm_rdata;
    dm_rdata <= dm_rd ? dword(dm_addr) : ~dm_rdata;
  end
endmodule : psa_mem_model
`default_nettype wire

// *** dv/tb_program_space_data_access.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench for the program space access block
module tb_program_space_data_access;
  logic clock, reset, table_page_we, visibility_page_we, program_visibility_enable, req_valid;
  logic req_byte, req_short_op, req_in_repeat, req_rep_edge, req_ready, rsp_valid, pm_rd;
  logic pm_wr_hi, dm_rd, dm_wr, dm_byte, x_space, psv_active;
  logic [7:0] table_page_wdata, visibility_page_wdata, table_page, visibility_page, tp, vp;
  logic [2:0] req_kind;
  logic [1:0] pm_wr_lo;
  logic [15:0] req_ea, req_wdata, rsp_data, dm_addr, dm_wdata, dm_rdata;
  logic [22:0] req_pc;
  logic [23:0] pm_addr, pm_wdata, pm_rdata, next_pc_addr;
  logic [31:0] rnd;
  int n_mismatch;
  int samples_checked;

  psa_access_top u_dut (.*);
  psa_mem_model u_mem (.*);

  // Core clock, 100 ns period
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // Load both page registers; entered and left at a rising edge
  task automatic set_pages(input logic [7:0] t, input logic [7:0] v);
    table_page_we <= 1'b1;
    visibility_page_we <= 1'b1;
    table_page_wdata <= t;
    visibility_page_wdata <= v;
    @(posedge clock);
    table_page_we <= 1'b0;
    visibility_page_we <= 1'b0;
    tp = t;
    vp = v;
    #1;
    chk("table_page", {16'h0000, t}, {16'h0000, table_page});
    chk("visibility_page", {16'h0000, v}, {16'h0000, visibility_page});
    @(posedge clock);
  endtask : set_pages

  // One access; f is {enable, short op, in repeat, loop edge}
  task automatic do_req(input logic [2:0] k, input logic b, input logic [15:0] ea,
                        input logic [15:0] w, input logic [22:0] pc, input logic [3:0] f);
    logic win;
    logic [23:0] pa, pw;
    logic [15:0] d;
    int e, n;
    win = (k == 3'h5 || k == 3'h6) && ea[15] && f[3];
    e = !win ? 0 : f[1] ? (f[0] ? 2 : 0) : (f[2] ? 1 : 2);
    pa = k == 3'h0 ? {1'b0, pc[22:1], 1'b0} : win ? {1'b0, vp, ea[14:0]} : {tp, ea};
    pw = u_mem.pword(pa);
    d = k == 3'h1 ? pw[15:0] : k == 3'h2 ? {8'h00, pw[23:16]} : win ? pw[15:0] : u_mem.dword(ea);
    if (b)
      d = (k == 3'h2) ? (ea[0] ? 16'h0000 : d) : {8'h00, ea[0] ? d[15:8] : d[7:0]};
    req_valid <= 1'b1;
    req_kind <= k;
    req_byte <= b;
    req_ea <= ea;
    req_wdata <= w;
    req_pc <= pc;
    program_visibility_enable <= f[3];
    {req_short_op, req_in_repeat, req_rep_edge} <= f[2:0];
    @(posedge clock);
    req_valid <= 1'b0;
    #1;
    chk("pm_rd", 24'(k < 3'h3 || (k == 3'h5 && win)), 24'(pm_rd));
    if (k < 3'h5 || (k == 3'h5 && win))
      chk("pm_addr", pa, pm_addr);
    chk("dm_rd", 24'(k == 3'h5 && !win), 24'(dm_rd));
    chk("dm_wr", 24'(k == 3'h6 && !win), 24'(dm_wr));
    chk("req_ready", 24'h000000, 24'(req_ready));
    if ((k == 3'h5 || k == 3'h6) && !win)
      chk("dm_addr", 24'(ea), 24'(dm_addr));
    if ((k == 3'h5 || k == 3'h6) && !win)
      chk("dm_byte", 24'(b), 24'(dm_byte));
    if (k == 3'h6 && !win)
      chk("dm_wdata", 24'(w), 24'(dm_wdata));
    chk("psv_active", 24'(win), 24'(psv_active));
    chk("pm_wr_lo", 24'(k != 3'h3 ? 0 : !b ? 3 : ea[0] ? 2 : 1), 24'(pm_wr_lo));
    chk("pm_wr_hi", 24'(k == 3'h4 && !(b && ea[0])), 24'(pm_wr_hi));
    if (k == 3'h3)
      chk("pm_wdata_lo", 24'(b ? {w[7:0], w[7:0]} : w), {8'h00, pm_wdata[15:0]});
    if (k == 3'h4)
      chk("pm_wdata_hi", 24'(w[7:0]), 24'(pm_wdata[23:16]));
    if (k == 3'h0)
      chk("next_pc_addr", pa + 24'h000002, next_pc_addr);
    if (k > 3'h4)
      chk("x_space", 24'(ea[15]), 24'(x_space));
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("latency", 24'(3 + e), 24'(n));
    if (k == 3'h1 || k == 3'h2 || k == 3'h5)
      chk("rsp_data", {8'h00, d}, {8'h00, rsp_data});
    @(posedge clock);
  endtask : do_req

  // ==========================================================
  // Main sequence
  initial
  begin
    {reset, table_page_we, visibility_page_we, program_visibility_enable, req_valid} = 5'h10;
    {req_byte, req_short_op, req_in_repeat, req_rep_edge, req_kind} = 7'h00;
    {table_page_wdata, visibility_page_wdata, req_ea, req_wdata, req_pc} = 71'h0;
    {tp, vp, n_mismatch, samples_checked} = 0;
    rnd = 32'h52ACE994;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    chk("reset_state", 24'h000001, {rsp_valid, table_page, visibility_page, 6'h00, req_ready});
    @(posedge clock);
    set_pages(8'h80, 8'hFF);
    for (int k = 0; k < 7; k++)
      for (int i = 0; i < 64; i++)
        do_req(3'(k), i[0], {i[5], 14'h1A5C, i[1]}, 16'hB6D1 ^ 16'(i), {7'h2B, 16'(i)},
               {1'b1, 3'(i >> 2)});
    $display("test directed done");
    for (int j = 0; j < 300; j++)
    begin
      rnd = lfsr(rnd);
      if (j % 16 == 0)
        set_pages(rnd[7:0], rnd[15:8]);
      do_req(3'(rnd[2:0] % 7), rnd[3], rnd[19:4], rnd[31:16], rnd[26:4], rnd[30:27]);
    end
    $display("test random done");
    tally_and_finish();
  end

  // Watchdog against a hung handshake
  initial
  begin
    repeat (30000) @(posedge clock);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : tb_program_space_data_access
`default_nettype wire
